// ==== hdl/stse_status_events.sv ====
`timescale 1ns/1ps

// How it works
// - High threshold bits 15:8 come from the high-threshold upper byte register.
// - Result above high threshold with persistence met raises the threshold event.
// - Result below low threshold with persistence met also raises it.
// - Low bytes wait in a latch, applied together when the upper byte is written.
// - Out-of-range must last the persistence count of consecutive measurements.
// - A 3-bit select picks channel 0 to 4 for comparison; reset picks 0.
// - Sync-wait bit shows waiting for a sync pulse in sync start modes.
// - Ready bit reads busy during a spectral measurement, ready afterwards.
// - Writing one to an event status bit clears it.
// - Writing zero leaves event bits set, so late events survive write-back.
// - Saturation event bit sets on spectral or flicker saturation when enabled.
// - Threshold event bit sets on a qualified threshold event when enabled.
// - Buffer event bit sets at fill threshold, re-sets after clear until empty.
// - System event bit sets when a system source is pending and enabled.
// - A finished multiplexer command flags a system event source.
// - Measurement-valid bit sets when a spectral measurement completes.
// - Counter saturation sets when a result reaches the step-derived maximum.
// - Spectral analog saturation bit sets on analog overrange.
// - Flicker analog saturation bit sets on flicker analog overrange.
// - Flicker counter saturation bit sets when its counter hits maximum.
module stse_status_events
    import stse_pkg::*;
(
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    input  wire stse_regbus_s i_reg,
    input  wire stse_meas_s   i_meas,
    input  wire stse_chan_t   i_chan_data,
    input  wire stse_sat_s    i_sat,
    input  wire stse_en_s     i_enables,
    input  wire logic [3:0]   i_persistence_count,
    input  wire logic [15:0]  i_integration_step_count,
    input  wire logic [7:0]   i_buffer_fill_level,
    input  wire logic [7:0]   i_buffer_level_threshold,
    input  wire logic         i_sensor_multiplexer_done,
    output logic [7:0]        o_reg_rdata,
    output logic [7:0]        o_event_status,
    output logic [15:0]       o_high_threshold,
    output logic [15:0]       o_low_threshold,
    output logic              o_sensor_multiplexer_source
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic wr_hit(input stse_regbus_s b, input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // Full-scale count grows with integration steps, capped at 16 bits
    function automatic logic [15:0] full_scale(input logic [15:0] steps);
        return (steps == FULL_SCALE) ? FULL_SCALE : steps + 16'h0001;
    endfunction

    // ----------------------------------------------------------------
    // Threshold registers and byte latches
    // ----------------------------------------------------------------
    logic [7:0]  low_lsb_latch_ff;
    logic [7:0]  high_lsb_latch_ff;
    logic [15:0] low_thresh_ff;
    logic [15:0] high_thresh_ff;
    logic [2:0]  compare_channel_select_ff;

    // Low bytes sit in a latch so a half-written threshold never applies
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            low_lsb_latch_ff  <= RST_BYTE;
            high_lsb_latch_ff <= RST_BYTE;
            low_thresh_ff     <= RST_THRESH;
            high_thresh_ff    <= RST_THRESH;
        end else begin
            if (wr_hit(i_reg, ADDR_LOW_LSB)) begin
                low_lsb_latch_ff <= i_reg.wdata;
            end
            if (wr_hit(i_reg, ADDR_HIGH_LSB)) begin
                high_lsb_latch_ff <= i_reg.wdata;
            end
            if (wr_hit(i_reg, ADDR_LOW_MSB)) begin
                low_thresh_ff <= {i_reg.wdata, low_lsb_latch_ff};
            end
            if (wr_hit(i_reg, ADDR_HIGH_MSB)) begin
                high_thresh_ff <= {i_reg.wdata, high_lsb_latch_ff};
            end
        end
    end

    // Channel select; codes above 4 are refused and keep the old choice
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            compare_channel_select_ff <= RST_CHAN;
        end else if (wr_hit(i_reg, ADDR_CHAN_SEL) && i_reg.wdata[2:0] <= CHAN_LAST) begin
            compare_channel_select_ff <= i_reg.wdata[2:0];
        end
    end

    assign o_high_threshold = high_thresh_ff;
    assign o_low_threshold  = low_thresh_ff;

    // ----------------------------------------------------------------
    // Threshold comparison with persistence
    // ----------------------------------------------------------------
    logic [15:0] sel_sample;
    logic        thresh_hit;

    assign sel_sample = i_chan_data[compare_channel_select_ff];

    stse_persist u_persist (
        .i_sys_clk      (i_sys_clk),
        .i_reset        (i_reset),
        .i_sample_valid (i_meas.done),
        .i_sample       (sel_sample),
        .i_low          (low_thresh_ff),
        .i_high         (high_thresh_ff),
        .i_persist      (i_persistence_count),
        .o_hit          (thresh_hit)
    );

    // ----------------------------------------------------------------
    // Measurement detail status
    // ----------------------------------------------------------------
    logic       busy_d_ff;
    logic       meas_start;
    logic       spec_cnt_sat;
    logic [7:0] detail_ff;
    logic [7:0] wait_ready_ff;

    assign meas_start = i_meas.busy && !busy_d_ff;

    // Counter saturation checked on every channel at the end of a run
    always_comb begin
        spec_cnt_sat = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (i_chan_data[c] >= full_scale(i_integration_step_count)) begin
                spec_cnt_sat = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            busy_d_ff <= 1'b0;
        end else begin
            busy_d_ff <= i_meas.busy;
        end
    end

    // Spectral bits restart with each run, flicker bits with each flicker run
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            detail_ff <= RST_BYTE;
        end else begin
            if (meas_start) begin
                detail_ff[DT_VALID]    <= 1'b0;
                detail_ff[DT_SPEC_CNT] <= 1'b0;
                detail_ff[DT_SPEC_ANA] <= 1'b0;
            end
            if (i_meas.flicker_start) begin
                detail_ff[DT_FLK_ANA] <= 1'b0;
                detail_ff[DT_FLK_CNT] <= 1'b0;
            end
            if (i_meas.done) begin
                detail_ff[DT_VALID] <= 1'b1;
            end
            if (i_meas.done && spec_cnt_sat) begin
                detail_ff[DT_SPEC_CNT] <= 1'b1;
            end
            if (i_sat.spec_analog) begin
                detail_ff[DT_SPEC_ANA] <= 1'b1;
            end
            if (i_sat.flick_analog) begin
                detail_ff[DT_FLK_ANA] <= 1'b1;
            end
            if (i_sat.flick_counter) begin
                detail_ff[DT_FLK_CNT] <= 1'b1;
            end
        end
    end

    // Wait and ready flags follow the engine one cycle late
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wait_ready_ff <= RST_BYTE;
        end else begin
            wait_ready_ff[ST_SYNC] <= i_meas.sync_wait &&
                (i_meas.sync_start_mode || i_meas.sync_start_stop_mode);
            wait_ready_ff[ST_READY] <= !i_meas.busy;
        end
    end

    // ----------------------------------------------------------------
    // System source and buffer re-arm
    // ----------------------------------------------------------------
    logic ev_clear_wr;
    logic buf_rearm_ff;
    logic sys_clear;

    assign ev_clear_wr = wr_hit(i_reg, ADDR_EVENT);
    // Host write-one to the system bit, used by both source and flag
    assign sys_clear   = ev_clear_wr && i_reg.wdata[EV_SYS];

    // Source drops only when the host clears the system event bit
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_sensor_multiplexer_source <= 1'b0;
        end else if (i_sensor_multiplexer_done) begin
            o_sensor_multiplexer_source <= 1'b1;
        end else if (sys_clear) begin
            o_sensor_multiplexer_source <= 1'b0;
        end
    end

    // After a clear the buffer bit comes back while any data remains
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            buf_rearm_ff <= 1'b0;
        end else if (i_buffer_fill_level == 8'h00) begin
            buf_rearm_ff <= 1'b0;
        end else if (ev_clear_wr && i_reg.wdata[EV_BUF]) begin
            buf_rearm_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Event status, write one to clear
    // ----------------------------------------------------------------
    localparam int EV_POS [NUM_EV] = '{EV_SAT, EV_THR, EV_BUF, EV_SYS};

    logic [NUM_EV-1:0] ev_set;
    logic [NUM_EV-1:0] ev_flag;
    logic              buf_cond;

    assign buf_cond = (i_buffer_fill_level >= i_buffer_level_threshold) ||
                      (buf_rearm_ff && i_buffer_fill_level != 8'h00);

    assign ev_set[0] = i_enables.saturation_event_enable &&
                       (i_sat.spec_analog || i_sat.flick_analog ||
                        i_sat.flick_counter || (i_meas.done && spec_cnt_sat));
    assign ev_set[1] = i_enables.threshold_event_enable && thresh_hit;
    assign ev_set[2] = i_enables.buffer_event_enable && buf_cond;
    // Without the mask a source being cleared would re-set the bit it clears
    assign ev_set[3] = i_enables.system_event_enable && o_sensor_multiplexer_source &&
                       !sys_clear;

    // Zero bits of a write-back leave their flags alone
    generate
        for (genvar g = 0; g < NUM_EV; g++) begin : g_ev
            stse_w1c_flag u_flag (
                .i_sys_clk (i_sys_clk),
                .i_reset   (i_reset),
                .i_set     (ev_set[g]),
                .i_clear   (ev_clear_wr && i_reg.wdata[EV_POS[g]]),
                .o_flag    (ev_flag[g])
            );
        end
    endgenerate

    always_comb begin
        o_event_status = RST_BYTE;
        for (int k = 0; k < NUM_EV; k++) begin
            o_event_status[EV_POS[k]] = ev_flag[k];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Registered read; unmapped offsets answer zero
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_reg_rdata <= RST_BYTE;
        end else if (i_reg.rd) begin
            unique case (i_reg.addr)
                ADDR_WAIT_READY: o_reg_rdata <= wait_ready_ff;
                ADDR_LOW_LSB:    o_reg_rdata <= low_lsb_latch_ff;
                ADDR_LOW_MSB:    o_reg_rdata <= low_thresh_ff[15:8];
                ADDR_HIGH_LSB:   o_reg_rdata <= high_lsb_latch_ff;
                ADDR_HIGH_MSB:   o_reg_rdata <= high_thresh_ff[15:8];
                ADDR_EVENT:      o_reg_rdata <= o_event_status;
                ADDR_DETAIL:     o_reg_rdata <= detail_ff;
                ADDR_CHAN_SEL:   o_reg_rdata <= {5'h00, compare_channel_select_ff};
                default:         o_reg_rdata <= RST_BYTE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_high_msb_apply: assert property (
        wr_hit(i_reg, ADDR_HIGH_MSB) |=> high_thresh_ff == {$past(i_reg.wdata), $past(high_lsb_latch_ff)})
        else $error("high threshold not applied from byte pair");

    a_lsb_held_back: assert property (
        (wr_hit(i_reg, ADDR_LOW_LSB) && !wr_hit(i_reg, ADDR_LOW_MSB)) |=> $stable(low_thresh_ff))
        else $error("low threshold changed without upper byte");

    a_chan_reset_zero: assert property (
        $past(i_reset) |-> compare_channel_select_ff == RST_CHAN)
        else $error("channel select not zero after reset");

    a_thr_event_sets: assert property (
        (thresh_hit && i_enables.threshold_event_enable) |=> o_event_status[EV_THR])
        else $error("threshold event bit not set");

    a_w1c_clears: assert property (
        (ev_clear_wr && i_reg.wdata[EV_SAT] && !ev_set[0]) |=> !o_event_status[EV_SAT])
        else $error("write one did not clear saturation bit");

    a_zero_keeps: assert property (
        (o_event_status[EV_THR] && ev_clear_wr && !i_reg.wdata[EV_THR]) |=> o_event_status[EV_THR])
        else $error("write zero cleared threshold bit");

    a_ready_tracks: assert property (
        i_meas.busy [*2] |-> !wait_ready_ff[ST_READY])
        else $error("ready shown during measurement");

    a_valid_on_done: assert property (
        i_meas.done |=> detail_ff[DT_VALID] ##1 (detail_ff[DT_VALID] || $past(meas_start)))
        else $error("valid bit not set on completion");

    a_sensor_multiplexer_to_sys: assert property (
        (i_sensor_multiplexer_done ##1 (i_enables.system_event_enable && !sys_clear))
        |=> o_event_status[EV_SYS])
        else $error("system event missing after mux command");

    a_sensor_multiplexer_flags_src: assert property (
        i_sensor_multiplexer_done |=> o_sensor_multiplexer_source)
        else $error("mux command did not flag its source");

    a_sync_needs_mode: assert property (
        !(i_meas.sync_start_mode || i_meas.sync_start_stop_mode) |=> !wait_ready_ff[ST_SYNC])
        else $error("sync wait shown outside sync modes");

    a_buf_rearm: assert property (
        (buf_rearm_ff && i_buffer_fill_level != 8'h00 && i_enables.buffer_event_enable)
        |=> o_event_status[EV_BUF])
        else $error("buffer event not re-raised while data remains");

endmodule

// ==== include/stse_pkg.sv ====
package stse_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WAIT_READY = 8'h71;
    localparam logic [7:0] ADDR_LOW_LSB    = 8'h84;
    localparam logic [7:0] ADDR_LOW_MSB    = 8'h85;
    localparam logic [7:0] ADDR_HIGH_LSB   = 8'h86;
    localparam logic [7:0] ADDR_HIGH_MSB   = 8'h87;
    localparam logic [7:0] ADDR_EVENT      = 8'h93;
    localparam logic [7:0] ADDR_DETAIL     = 8'ha3;
    localparam logic [7:0] ADDR_CHAN_SEL   = 8'hb5;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int EV_SAT      = 7;
    localparam int EV_THR      = 3;
    localparam int EV_BUF      = 2;
    localparam int EV_SYS      = 0;
    localparam int DT_VALID    = 6;
    localparam int DT_SPEC_CNT = 4;
    localparam int DT_SPEC_ANA = 3;
    localparam int DT_FLK_ANA  = 1;
    localparam int DT_FLK_CNT  = 0;
    localparam int ST_SYNC     = 1;
    localparam int ST_READY    = 0;
    localparam int NUM_CH      = 5;
    localparam int NUM_EV      = 4;

    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [2:0]  RST_CHAN   = 3'h0;
    localparam logic [2:0]  CHAN_LAST  = 3'h4;
    localparam logic [15:0] FULL_SCALE = 16'hffff;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef logic [NUM_CH-1:0][15:0] stse_chan_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } stse_regbus_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic sync_wait;
        logic sync_start_mode;
        logic sync_start_stop_mode;
        logic flicker_start;
    } stse_meas_s;

    typedef struct packed {
        logic spec_analog;
        logic flick_analog;
        logic flick_counter;
    } stse_sat_s;

    typedef struct packed {
        logic threshold_event_enable;
        logic saturation_event_enable;
        logic buffer_event_enable;
        logic system_event_enable;
    } stse_en_s;

endpackage

// ==== hdl/stse_w1c_flag.sv ====
`timescale 1ns/1ps
module stse_w1c_flag
    import stse_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);

    // ----------------------------------------------------------------
    // Sticky flag
    // ----------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

    a_set_wins_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_set |=> o_flag)
        else $error("sticky flag lost a set");

endmodule

// ==== hdl/stse_persist.sv ====
`timescale 1ns/1ps
module stse_persist
    import stse_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_sample_valid,
    input  wire logic [15:0] i_sample,
    input  wire logic [15:0] i_low,
    input  wire logic [15:0] i_high,
    input  wire logic [3:0]  i_persist,
    output logic             o_hit
);

    logic       above;
    logic       below;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [3:0] need;

    assign above = i_sample > i_high;
    assign below = i_sample < i_low;
    // A zero setting still needs one out-of-range sample
    assign need  = (i_persist == 4'h0) ? 4'h1 : i_persist;
    assign nxt_cnt = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;

    // ----------------------------------------------------------------
    // Consecutive out-of-range counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cnt_ff <= 4'h0;
            o_hit  <= 1'b0;
        end else begin
            o_hit <= 1'b0;
            if (i_sample_valid) begin
                if (above || below) begin
                    cnt_ff <= nxt_cnt;
                    o_hit  <= nxt_cnt >= need;
                end else begin
                    cnt_ff <= 4'h0;
                end
            end
        end
    end

    a_inrange_no_hit: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_sample_valid && !(i_sample > i_high) && !(i_sample < i_low)) |=> !o_hit)
        else $error("hit raised for in-range sample");

endmodule

// ==== testbench/stse_host_model.sv ====
`timescale 1ns/1ps
module stse_host_model
    import stse_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    output stse_regbus_s    o_reg
);
    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Idle bus shows inverted leftovers, so stale values never look valid
    initial o_reg = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // One write strobe per byte, changed only at falling edges
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_sys_clk);
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Read data is registered, so it is taken one edge after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_sys_clk);
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = i_reg_rdata;
    endtask

    // Write back what was seen, so later events are not lost
    task automatic service_events(output logic [7:0] seen);
        read_reg(ADDR_EVENT, seen);
        write_reg(ADDR_EVENT, seen);
    endtask
endmodule

// ==== testbench/spectral_threshold_status_events_bench.sv ====
`timescale 1ns/1ps
module spectral_threshold_status_events_bench
    import stse_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic         sys_clk = 1'b0;
    logic         reset   = 1'b1;
    stse_regbus_s reg_bus;
    stse_meas_s   meas    = '0;
    stse_chan_t   chan    = '0;
    stse_sat_s    sat     = '0;
    stse_en_s     en      = '1;
    logic [3:0]   persist = 4'h2;
    logic [15:0]  step    = 16'hffff;
    logic [7:0]   fill    = 8'h00;
    logic [7:0]   fill_th = 8'h04;
    logic         sensor_multiplexer    = 1'b0;
    logic [7:0]   rdata;
    logic [7:0]   ev;
    logic [7:0]   seen;
    logic [15:0]  high_th;
    logic [15:0]  low_th;
    logic         sensor_multiplexer_src;
    int           fail_count = 0;
    int           tests_run  = 0;
    int           cycles     = 0;

    // Free-running 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    stse_status_events dut (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_reg(reg_bus), .i_meas(meas),
        .i_chan_data(chan), .i_sat(sat), .i_enables(en), .i_persistence_count(persist),
        .i_integration_step_count(step), .i_buffer_fill_level(fill),
        .i_buffer_level_threshold(fill_th), .i_sensor_multiplexer_done(sensor_multiplexer), .o_reg_rdata(rdata),
        .o_event_status(ev), .o_high_threshold(high_th), .o_low_threshold(low_th),
        .o_sensor_multiplexer_source(sensor_multiplexer_src));

    stse_host_model host (.i_sys_clk(sys_clk), .i_reg_rdata(rdata), .o_reg(reg_bus));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic results();
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk8(d, exp);
    endtask

    // One measurement result on one channel, others read zero
    task automatic done_with(input int ch, input logic [15:0] v);
        chan = '0;
        chan[ch] = v;
        meas.done = 1'b1;
        tick(1);
        meas.done = 1'b0;
        tick(1);
    endtask

    // Hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(16);
        reset = 1'b0;
        rd_chk(ADDR_WAIT_READY, 8'h01);
        rd_chk(ADDR_EVENT, RST_BYTE);
        rd_chk(ADDR_DETAIL, RST_BYTE);
        rd_chk(ADDR_HIGH_MSB, RST_BYTE);
        rd_chk(ADDR_CHAN_SEL, RST_BYTE);
        meas.busy = 1'b1;
        meas.sync_start_mode = 1'b1;
        meas.sync_wait = 1'b1;
        rd_chk(ADDR_WAIT_READY, 8'h02);
        meas = '0;
        rd_chk(ADDR_WAIT_READY, 8'h01);
        host.write_reg(ADDR_HIGH_LSB, 8'h34);
        chk16(high_th, RST_THRESH);
        host.write_reg(ADDR_HIGH_MSB, 8'h12);
        chk16(high_th, 16'h1234);
        rd_chk(ADDR_HIGH_MSB, 8'h12);
        host.write_reg(ADDR_LOW_LSB, 8'h10);
        host.write_reg(ADDR_LOW_MSB, 8'h00);
        chk16(low_th, 16'h0010);
        host.write_reg(ADDR_CHAN_SEL, 8'h05);
        rd_chk(ADDR_CHAN_SEL, RST_BYTE);
        host.write_reg(ADDR_CHAN_SEL, 8'h02);
        rd_chk(ADDR_CHAN_SEL, 8'h02);
        // In-range result in between must restart the persistence run
        done_with(2, 16'h2000);
        done_with(2, 16'h1234);
        done_with(2, 16'h2000);
        tick(2);
        chk8(ev, RST_BYTE);
        done_with(2, 16'h2000);
        tick(2);
        chk8(ev, 8'h08);
        host.write_reg(ADDR_EVENT, 8'h00);
        chk8(ev, 8'h08);
        host.write_reg(ADDR_EVENT, 8'h08);
        chk8(ev, RST_BYTE);
        done_with(2, 16'h0010);
        done_with(2, 16'h0005);
        tick(2);
        chk8(ev, RST_BYTE);
        done_with(2, 16'h0005);
        tick(2);
        chk8(ev, 8'h08);
        host.service_events(seen);
        chk8(seen, 8'h08);
        chk8(ev, RST_BYTE);
        en.threshold_event_enable = 1'b0;
        en.saturation_event_enable = 1'b0;
        done_with(2, 16'h0005);
        sat.spec_analog = 1'b1;
        tick(1);
        sat = '0;
        tick(2);
        chk8(ev, RST_BYTE);
        rd_chk(ADDR_DETAIL, 8'h48);
        en.saturation_event_enable = 1'b1;
        sat.flick_analog = 1'b1;
        tick(1);
        sat = '0;
        tick(2);
        chk8(ev, 8'h80);
        rd_chk(ADDR_DETAIL, 8'h4a);
        sat.flick_counter = 1'b1;
        tick(1);
        sat = '0;
        rd_chk(ADDR_DETAIL, 8'h4b);
        host.write_reg(ADDR_EVENT, 8'h80);
        chk8(ev, RST_BYTE);
        // Full scale is step count plus one
        step = 16'h00ff;
        done_with(0, 16'h0100);
        tick(2);
        rd_chk(ADDR_DETAIL, 8'h5b);
        chk8(ev, 8'h80);
        host.write_reg(ADDR_EVENT, 8'h80);
        fill = 8'h04;
        tick(2);
        chk8(ev, 8'h04);
        fill = 8'h02;
        host.write_reg(ADDR_EVENT, 8'h04);
        tick(2);
        chk8(ev, 8'h04);
        fill = 8'h00;
        host.write_reg(ADDR_EVENT, 8'h04);
        tick(2);
        chk8(ev, RST_BYTE);
        sensor_multiplexer = 1'b1;
        tick(1);
        sensor_multiplexer = 1'b0;
        tick(2);
        chk8(ev, 8'h01);
        chk8({7'h00, sensor_multiplexer_src}, 8'h01);
        host.write_reg(ADDR_EVENT, 8'h01);
        chk8(ev, RST_BYTE);
        // Flicker start drops only the flicker bits, a new run the spectral ones
        meas.flicker_start = 1'b1;
        tick(1);
        meas.flicker_start = 1'b0;
        rd_chk(ADDR_DETAIL, 8'h58);
        meas.busy = 1'b1;
        meas.sync_wait = 1'b1;
        rd_chk(ADDR_WAIT_READY, 8'h00);
        rd_chk(ADDR_DETAIL, RST_BYTE);
        meas.sync_start_stop_mode = 1'b1;
        rd_chk(ADDR_WAIT_READY, 8'h02);
        meas = '0;
        results();
    end
endmodule
